/* File: hw/iapfc_top.v */
/*
 * In-application programming controller for the program flash: registers,
 * enable procedure, page buffer loading, page erase, page write, word read.
 * Assumes a byte-wide register port in the core_clk domain.
 */
// Design decisions made here: the register addresses and the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none
`include "iapfc_consts.vh"

module iapfc_top #(
    parameter PAGE_WORDS = 32,
    parameter [15:0] UNLOCK_WINDOW = `IAPFC_UNLOCK_WINDOW_CYCLES,
    parameter [15:0] ERASE_TIME = `IAPFC_ERASE_CYCLES,
    parameter [15:0] WRITE_TIME = `IAPFC_WRITE_CYCLES
) (
    input wire core_clk,
    input wire nrst,
    input wire [3:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [7:0] reg_rdata,
    output wire busy
);
    localparam [4:0] ST_IDLE = 5'h01;
    localparam [4:0] ST_ERASE = 5'h02;
    localparam [4:0] ST_WRITE = 5'h04;
    localparam [4:0] ST_READ = 5'h08;
    localparam [4:0] ST_CLEAR = 5'h10;
    localparam [4:0] LAST_WORD = 5'h1F;

    reg [4:0] state;
    reg [15:0] timer;
    reg [4:0] word_idx;
    reg enabled_flag;
    reg [2:0] op_mode;
    reg proc_trig;
    reg write_start;
    reg read_enable;
    reg read_start;
    reg clear_start;
    reg timeout_flag;
    reg [7:0] key_reg;
    reg [1:0] key_step;
    reg [13:0] flash_addr;
    // address held for the running operation; software may move its own
    // address register meanwhile without steering the array elsewhere
    reg [13:0] op_addr;
    reg [15:0] unlock_timer;
    reg [7:0] data_low [0:3];
    reg [7:0] data_high [0:3];
    wire [15:0] buf_word;
    wire buf_valid;
    wire [15:0] array_word;
    wire [8:0] page_sel;
    wire buf_load;
    wire buf_clear;
    wire wr_ctrl0;
    wire [13:0] next_addr;
    wire start_write;
    wire start_erase;
    wire start_read;
    wire start_clear;
    integer k;

    // ======================================================
    // helper functions
    function [7:0] iapfc_unlock_key;
        input [1:0] step;
        begin
            case (step)
                2'd0: iapfc_unlock_key = `IAPFC_UNLOCK_KEY0;
                2'd1: iapfc_unlock_key = `IAPFC_UNLOCK_KEY1;
                2'd2: iapfc_unlock_key = `IAPFC_UNLOCK_KEY2;
                default: iapfc_unlock_key = `IAPFC_UNLOCK_KEY3;
            endcase
        end
    endfunction

    // start bit and mode field of one control-0 write
    function iapfc_start_hit;
        input [7:0] wdata;
        input [2:0] mode;
        input integer start_bit;
        begin
            iapfc_start_hit = wdata[start_bit]
                && (wdata[`IAPFC_C0_MODE_HI:`IAPFC_C0_MODE_LO] == mode);
        end
    endfunction

    // ======================================================
    // decode and addressing
    assign page_sel = op_addr[13:5];
    assign wr_ctrl0 = reg_wr && (reg_addr == `IAPFC_OFS_CTRL0);
    // high byte write in idle with erase/write enabled loads the buffer
    assign buf_load = reg_wr && (reg_addr == `IAPFC_OFS_DATA0_HIGH)
        && enabled_flag && (state == ST_IDLE);
    // stop at the page's last word rather than wrap into the next page
    assign next_addr = (flash_addr[4:0] == LAST_WORD) ? flash_addr
        : flash_addr + 14'd1;
    assign buf_clear = (state == ST_WRITE && timer == 16'd0
        && word_idx == LAST_WORD) || (state == ST_CLEAR);
    assign busy = (state != ST_IDLE);
    assign start_write = wr_ctrl0 && enabled_flag
        && iapfc_start_hit(reg_wdata, `IAPFC_MODE_WRITE, `IAPFC_C0_WRITE_START);
    // erase shares the write start bit; only the mode tells them apart
    assign start_erase = wr_ctrl0 && enabled_flag
        && iapfc_start_hit(reg_wdata, `IAPFC_MODE_ERASE, `IAPFC_C0_WRITE_START);
    // read enable must come in the same write as the read start
    assign start_read = wr_ctrl0 && reg_wdata[`IAPFC_C0_READ_EN]
        && iapfc_start_hit(reg_wdata, `IAPFC_MODE_READ, `IAPFC_C0_READ_START);
    assign start_clear = reg_wr && (reg_addr == `IAPFC_OFS_CTRL2)
        && reg_wdata[`IAPFC_C2_CLEAR_START];

    iapfc_wbuf #(
        .WORDS(PAGE_WORDS),
        .AW(5)
    ) u_wbuf (
        .core_clk(core_clk),
        .nrst(nrst),
        .load(buf_load),
        .load_addr(flash_addr[4:0]),
        .load_data({reg_wdata, data_low[0]}),
        .clear(buf_clear),
        .rd_addr(word_idx),
        .rd_data(buf_word),
        .rd_valid(buf_valid)
    );

    iapfc_array u_array (
        .core_clk(core_clk),
        .erase_word(state == ST_ERASE && timer == 16'd0),
        .prog_word(state == ST_WRITE && timer == 16'd0 && buf_valid),
        .addr(state == ST_READ ? op_addr : {page_sel, word_idx}),
        .wdata(buf_word),
        .rdata(array_word)
    );

    // ======================================================
    // registers and sequencer
    always @(posedge core_clk) begin
        if (!nrst) begin
            state <= ST_IDLE;
            timer <= 16'd0;
            word_idx <= 5'd0;
            enabled_flag <= 1'b0;
            op_mode <= 3'd0;
            proc_trig <= 1'b0;
            write_start <= 1'b0;
            read_enable <= 1'b0;
            read_start <= 1'b0;
            clear_start <= 1'b0;
            timeout_flag <= 1'b0;
            key_reg <= `IAPFC_RESET_BYTE;
            key_step <= 2'd0;
            flash_addr <= 14'd0;
            op_addr <= 14'h0000;
            unlock_timer <= 16'h0000;
            for (k = 0; k < 4; k = k + 1) begin
                data_low[k] <= `IAPFC_RESET_BYTE;
                data_high[k] <= `IAPFC_RESET_BYTE;
            end
        end else begin
            // ---- software writes
            if (reg_wr) begin
                case (reg_addr)
                    `IAPFC_OFS_CTRL0: begin
                        if (!reg_wdata[`IAPFC_C0_ENABLED]) begin
                            enabled_flag <= 1'b0;
                        end
                        op_mode <= reg_wdata[`IAPFC_C0_MODE_HI:`IAPFC_C0_MODE_LO];
                        read_enable <= reg_wdata[`IAPFC_C0_READ_EN];
                        if (reg_wdata[`IAPFC_C0_PROC_TRIG] && !proc_trig) begin
                            proc_trig <= 1'b1;
                            unlock_timer <= UNLOCK_WINDOW;
                            key_step <= 2'd0;
                            timeout_flag <= 1'b0;
                        end
                    end
                    `IAPFC_OFS_CTRL1: begin
                        key_reg <= reg_wdata;
                        // enable only after the full key sequence inside the window
                        if (proc_trig && op_mode == `IAPFC_MODE_ENABLE) begin
                            if (reg_wdata == iapfc_unlock_key(key_step)) begin
                                key_step <= key_step + 2'd1;
                                if (key_step == 2'd3) begin
                                    enabled_flag <= 1'b1;
                                    proc_trig <= 1'b0;
                                end
                            end else begin
                                key_step <= 2'd0;
                            end
                        end
                    end
                    `IAPFC_OFS_CTRL2: begin
                        if (!reg_wdata[`IAPFC_C2_TIMEOUT]) begin
                            timeout_flag <= 1'b0;
                        end
                    end
                    `IAPFC_OFS_ADDR_LOW: flash_addr[7:0] <= reg_wdata;
                    `IAPFC_OFS_ADDR_HIGH: flash_addr[13:8] <= reg_wdata[5:0];
                    `IAPFC_OFS_DATA0_LOW: data_low[0] <= reg_wdata;
                    `IAPFC_OFS_DATA0_HIGH: data_high[0] <= reg_wdata;
                    `IAPFC_OFS_DATA1_LOW: data_low[1] <= reg_wdata;
                    `IAPFC_OFS_DATA1_HIGH: data_high[1] <= reg_wdata;
                    `IAPFC_OFS_DATA2_LOW: data_low[2] <= reg_wdata;
                    `IAPFC_OFS_DATA2_HIGH: data_high[2] <= reg_wdata;
                    `IAPFC_OFS_DATA3_LOW: data_low[3] <= reg_wdata;
                    `IAPFC_OFS_DATA3_HIGH: data_high[3] <= reg_wdata;
                    default: ;
                endcase
            end
            if (buf_load) begin
                flash_addr <= next_addr;
            end
            // ---- enable procedure window times out; own counter, so an
            // operation started meanwhile neither stretches nor cuts it
            if (proc_trig) begin
                if (unlock_timer == 16'h0000) begin
                    proc_trig <= 1'b0;
                    timeout_flag <= 1'b1;
                end else begin
                    unlock_timer <= unlock_timer - 16'h0001;
                end
            end
            // ---- sequencer
            case (state)
                ST_IDLE: begin
                    if (start_write) begin
                        write_start <= 1'b1;
                        word_idx <= 5'd0;
                        timer <= WRITE_TIME;
                        op_addr <= flash_addr;
                        state <= ST_WRITE;
                    end else if (start_erase) begin
                        write_start <= 1'b1;
                        word_idx <= 5'd0;
                        timer <= ERASE_TIME;
                        op_addr <= flash_addr;
                        state <= ST_ERASE;
                    end else if (start_read) begin
                        read_start <= 1'b1;
                        timer <= `IAPFC_READ_CYCLES;
                        op_addr <= flash_addr;
                        state <= ST_READ;
                    end else if (start_clear) begin
                        clear_start <= 1'b1;
                        state <= ST_CLEAR;
                    end
                end
                ST_ERASE, ST_WRITE: begin
                    // whole page walked one word per step
                    if (timer != 16'd0) begin
                        timer <= timer - 16'd1;
                    end else if (word_idx == LAST_WORD) begin
                        write_start <= 1'b0;
                        state <= ST_IDLE;
                    end else begin
                        word_idx <= word_idx + 5'd1;
                        // every word gets its own program or erase dwell
                        timer <= (state == ST_WRITE) ? WRITE_TIME : ERASE_TIME;
                    end
                end
                ST_READ: begin
                    if (timer != 16'd0) begin
                        timer <= timer - 16'd1;
                    end else begin
                        data_low[0] <= array_word[7:0];
                        data_high[0] <= array_word[15:8];
                        read_start <= 1'b0;
                        state <= ST_IDLE;
                    end
                end
                ST_CLEAR: begin
                    // one cycle is enough: the buffer empties on this edge
                    clear_start <= 1'b0;
                    state <= ST_IDLE;
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // ======================================================
    // read port, data one cycle after the strobe
    always @(posedge core_clk) begin
        if (!nrst) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            case (reg_addr)
                `IAPFC_OFS_CTRL0: reg_rdata <= {enabled_flag, op_mode, proc_trig,
                    write_start, read_enable, read_start};
                `IAPFC_OFS_CTRL1: reg_rdata <= key_reg;
                `IAPFC_OFS_CTRL2: reg_rdata <= {6'd0, timeout_flag, clear_start};
                `IAPFC_OFS_ADDR_LOW: reg_rdata <= flash_addr[7:0];
                `IAPFC_OFS_ADDR_HIGH: reg_rdata <= {2'b00, flash_addr[13:8]};
                `IAPFC_OFS_DATA0_LOW: reg_rdata <= data_low[0];
                `IAPFC_OFS_DATA0_HIGH: reg_rdata <= data_high[0];
                `IAPFC_OFS_DATA1_LOW: reg_rdata <= data_low[1];
                `IAPFC_OFS_DATA1_HIGH: reg_rdata <= data_high[1];
                `IAPFC_OFS_DATA2_LOW: reg_rdata <= data_low[2];
                `IAPFC_OFS_DATA2_HIGH: reg_rdata <= data_high[2];
                `IAPFC_OFS_DATA3_LOW: reg_rdata <= data_low[3];
                `IAPFC_OFS_DATA3_HIGH: reg_rdata <= data_high[3];
                default: reg_rdata <= 8'h00;
            endcase
        end else begin
            reg_rdata <= 8'h00;
        end
    end
endmodule
`default_nettype wire

/* File: pkg/iapfc_consts.vh */
/*
 * Register offsets, field positions, mode codes and timing counts for the
 * flash program controller. Assumes inclusion by bare name from hw files.
 */
`ifndef IAPFC_CONSTS_VH
`define IAPFC_CONSTS_VH

// ==========================================================
// register offsets (byte wide registers)
`define IAPFC_OFS_CTRL0 4'h0
`define IAPFC_OFS_CTRL1 4'h1
`define IAPFC_OFS_CTRL2 4'h2
`define IAPFC_OFS_ADDR_LOW 4'h3
`define IAPFC_OFS_ADDR_HIGH 4'h4
`define IAPFC_OFS_DATA0_LOW 4'h5
`define IAPFC_OFS_DATA0_HIGH 4'h6
`define IAPFC_OFS_DATA1_LOW 4'h7
`define IAPFC_OFS_DATA1_HIGH 4'h8
`define IAPFC_OFS_DATA2_LOW 4'h9
`define IAPFC_OFS_DATA2_HIGH 4'hA
`define IAPFC_OFS_DATA3_LOW 4'hB
`define IAPFC_OFS_DATA3_HIGH 4'hC

// ==========================================================
// control register 0 fields
`define IAPFC_C0_ENABLED 7
`define IAPFC_C0_MODE_HI 6
`define IAPFC_C0_MODE_LO 4
`define IAPFC_C0_PROC_TRIG 3
`define IAPFC_C0_WRITE_START 2
`define IAPFC_C0_READ_EN 1
`define IAPFC_C0_READ_START 0
// control register 2 fields
`define IAPFC_C2_TIMEOUT 1
`define IAPFC_C2_CLEAR_START 0

// ==========================================================
// operation mode codes
`define IAPFC_MODE_WRITE 3'h0
`define IAPFC_MODE_ERASE 3'h1
`define IAPFC_MODE_READ 3'h3
`define IAPFC_MODE_ENABLE 3'h6

// ==========================================================
// reset values and timing
`define IAPFC_RESET_BYTE 8'h00
`define IAPFC_ADDR_HIGH_MASK 8'h3F
`define IAPFC_UNLOCK_KEY0 8'h55
`define IAPFC_UNLOCK_KEY1 8'hAA
`define IAPFC_UNLOCK_KEY2 8'hC3
`define IAPFC_UNLOCK_KEY3 8'h3C
`define IAPFC_UNLOCK_WINDOW_CYCLES 16'd1024
`define IAPFC_ERASE_CYCLES 16'd2048
`define IAPFC_WRITE_CYCLES 16'd2048
`define IAPFC_READ_CYCLES 16'd4

`endif

/* File: hw/iapfc_wbuf.v */
/*
 * Page write buffer: one word per in-page address plus a valid bit per word.
 * Assumes a single clock and that clear and load never coincide.
 */
`timescale 1ns/10ps
`default_nettype none
`include "iapfc_consts.vh"

module iapfc_wbuf #(
    parameter WORDS = 32,
    parameter AW = 5
) (
    input wire core_clk,
    input wire nrst,
    input wire load,
    input wire [AW-1:0] load_addr,
    input wire [15:0] load_data,
    input wire clear,
    input wire [AW-1:0] rd_addr,
    output wire [15:0] rd_data,
    output wire rd_valid
);
    reg [15:0] mem [0:WORDS-1];
    reg [WORDS-1:0] valid;
    integer i;

    // ======================================================
    // storage; a cleared word reads as erased (all ones)
    always @(posedge core_clk) begin
        if (!nrst || clear) begin
            valid <= {WORDS{1'b0}};
            for (i = 0; i < WORDS; i = i + 1) begin
                mem[i] <= 16'hFFFF;
            end
        end else if (load) begin
            mem[load_addr] <= load_data;
            valid[load_addr] <= 1'b1;
        end
    end

    assign rd_data = mem[rd_addr];
    assign rd_valid = valid[rd_addr];
endmodule
`default_nettype wire

/* File: hw/iapfc_array.v */
/*
 * Behavioural stand-in for the 16K x 16 program flash array.
 * Assumes the sequencer keeps erase, program and read exclusive.
 */
`timescale 1ns/10ps
`default_nettype none
`include "iapfc_consts.vh"

module iapfc_array #(
    parameter DEPTH = 16384,
    parameter AW = 14
) (
    input wire core_clk,
    input wire erase_word,
    input wire prog_word,
    input wire [AW-1:0] addr,
    input wire [15:0] wdata,
    output reg [15:0] rdata
);
    reg [15:0] mem [0:DEPTH-1];

    // ======================================================
    // programming can only pull bits low, like real cells
    always @(posedge core_clk) begin
        if (erase_word) begin
            mem[addr] <= 16'hFFFF;
        end else if (prog_word) begin
            mem[addr] <= mem[addr] & wdata;
        end
        rdata <= mem[addr];
    end
endmodule
`default_nettype wire

/* File: tb/iapfc_assertions.sv */
/*
 * Port checker for the flash program controller top.
 * Assumes the byte register port and busy, all in the core_clk domain.
 */
`timescale 1ns/10ps
`default_nettype none
module iapfc_checker (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic busy
);
    // ====================
    // helpers
    logic en_zero;
    wire logic c0 = reg_wr && reg_addr == 4'h0 && !busy;
    wire logic [2:0] md = reg_wdata[6:4];

    // flag surely low: no key written since reset or since software cleared it
    always_ff @(posedge core_clk) begin
        if (!nrst) en_zero <= 1'h1;
        else if (reg_wr && reg_addr == 4'h1) en_zero <= 1'h0;
        else if (reg_wr && reg_addr == 4'h0 && !reg_wdata[7]) en_zero <= 1'h1;
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);

    // ====================
    // properties
    sequence s_hi_wr; reg_wr && reg_addr == 4'h4; endsequence
    sequence s_hi_rd; reg_rd && reg_addr == 4'h4; endsequence
    sequence s_read_run; busy [*4] ##[1:2] !busy; endsequence
    sequence s_clear_run; busy ##[1:2] !busy; endsequence
    property p_reset_quiet; $rose(nrst) |-> !busy && reg_rdata == 8'h00; endproperty
    property p_page_bits;
        s_hi_wr ##2 s_hi_rd |=> reg_rdata == ($past(reg_wdata, 3) & 8'h3F);
    endproperty
    property p_read_run; c0 && md == 3'h3 && reg_wdata[1:0] == 2'h3 |=> s_read_run; endproperty
    property p_read_refused; c0 && md == 3'h3 && reg_wdata[1:0] == 2'h1 |=> !busy; endproperty
    property p_reserved; c0 && md inside {3'h2, 3'h4, 3'h5, 3'h7} |=> !busy; endproperty
    property p_clear_run;
        reg_wr && reg_addr == 4'h2 && reg_wdata[0] && !busy |=> s_clear_run;
    endproperty
    property p_flag_low; reg_rd && reg_addr == 4'h0 && en_zero |=> !reg_rdata[7]; endproperty
    property p_start_locked; c0 && md < 3'h2 && reg_wdata[2] && en_zero |=> !busy; endproperty

    a_reset_quiet: assert property (p_reset_quiet)
        else $error("busy or read data set after reset");
    a_page_bits: assert property (p_page_bits)
        else $error("address high byte not masked to page bits");
    a_read_run: assert property (p_read_run)
        else $error("word read did not run for its length");
    a_read_refused: assert property (p_read_refused)
        else $error("read started without read enable");
    a_reserved: assert property (p_reserved)
        else $error("reserved mode started an operation");
    a_clear_run: assert property (p_clear_run)
        else $error("buffer clear did not finish in time");
    a_flag_low: assert property (p_flag_low)
        else $error("enabled flag high without unlock keys");
    a_start_locked: assert property (p_start_locked)
        else $error("erase or write started while disabled");
endmodule

bind iapfc_top iapfc_checker iapfc_checker_i (
    .core_clk(core_clk),
    .nrst(nrst),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .busy(busy)
);
`default_nettype wire

/* File: tb/tb.sv */
/*
 * Self-checking bench for the flash program controller top.
 * Assumes short erase, write and unlock counts and erased words of all ones.
 */
`timescale 1ns/10ps
`default_nettype none
module tb;
    logic core_clk = 1'h0;
    logic nrst = 1'h0;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'h0;
    logic reg_rd = 1'h0;
    logic [7:0] reg_rdata;
    logic busy;
    logic [7:0] got;
    int errors = 0;
    int checks_done = 0;
    // index, byte written, byte read back
    localparam logic [19:0] rows [0:11] = '{20'h3A5A5, 20'h4FF3F, 20'h75A5A, 20'h8C3C3,
        20'h91111, 20'hA2222, 20'hB3333, 20'hC4444, 20'hD7700, 20'hF9900, 20'h08000, 20'h55A5A};
    localparam logic [7:0] keys [0:3] = '{8'h55, 8'hAA, 8'hC3, 8'h3C};
    localparam logic [2:0] resv [0:3] = '{3'h2, 3'h4, 3'h5, 3'h7};

    iapfc_top #(.UNLOCK_WINDOW(16'h0014), .ERASE_TIME(16'h0002), .WRITE_TIME(16'h0002))
    iapfc_top_i (
        .core_clk(core_clk),
        .nrst(nrst),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_wr(reg_wr),
        .reg_rd(reg_rd),
        .reg_rdata(reg_rdata),
        .busy(busy)
    );

    initial begin
        forever #4 core_clk = ~core_clk;
    end

    // ====================
    // bus and compare tasks
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        checks_done++;
        if (g !== e) begin
            errors++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic chk_busy();
        @(negedge core_clk);
        chk({7'h00, busy}, 8'h00);
        @(posedge core_clk);
    endtask
    // an idle cycle after each strobe keeps one assignment per signal per edge
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'h1;
        @(posedge core_clk);
        reg_wr <= 1'h0;
        @(posedge core_clk);
    endtask
    task automatic rd(input logic [3:0] a);
        reg_addr <= a;
        reg_rd <= 1'h1;
        @(posedge core_clk);
        reg_rd <= 1'h0;
        @(negedge core_clk);
        got = reg_rdata;
        @(posedge core_clk);
    endtask
    task automatic wait_idle();
        int n;
        n = 0;
        @(negedge core_clk);
        while (busy !== 1'h0 && n < 3000) begin
            @(negedge core_clk);
            n++;
        end
        if (n >= 3000) begin
            errors++;
            report_and_stop();
        end else begin
            @(posedge core_clk);
        end
    endtask
    task automatic op(input logic [7:0] v);
        wr(4'h0, v);
        wait_idle();
    endtask
    task automatic rdw(input logic [7:0] j, input logic [15:0] e);
        wr(4'h3, 8'hE0 + j);
        wr(4'h4, 8'h00);
        op(8'hB3);
        rd(4'h5);
        chk(got, e[7:0]);
        rd(4'h6);
        chk(got, e[15:8]);
    endtask
    task automatic done(input string s);
        $display("test %s finished", s);
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // ====================
    // main sequence
    initial begin
        repeat (16) @(posedge core_clk);
        nrst <= 1'h1;
        @(posedge core_clk);
        for (int i = 0; i < 13; i++) begin
            rd(i[3:0]);
            chk(got, 8'h00);
        end
        done("reset");
        for (int i = 0; i < 12; i++) begin
            wr(rows[i][19:16], rows[i][15:8]);
            rd(rows[i][19:16]);
            chk(got, rows[i][7:0]);
        end
        done("rows");
        wr(4'h6, 8'h12);
        rd(4'h3);
        chk(got, 8'hA5);
        wr(4'h0, 8'h04);
        chk_busy();
        done("locked");
        wr(4'h0, 8'h68);
        for (int k = 0; k < 3; k++) wr(4'h1, keys[k]);
        rd(4'h0);
        chk({7'h00, got[7]}, 8'h00);
        wr(4'h1, keys[3]);
        rd(4'h0);
        chk({7'h00, got[7]}, 8'h01);
        for (int k = 0; k < 4; k++) begin
            wr(4'h0, {1'h1, resv[k], 4'h4});
            chk_busy();
        end
        wr(4'h0, 8'hB1);
        chk_busy();
        done("unlock");
        wr(4'h3, 8'hE0);
        wr(4'h4, 8'h00);
        op(8'h94);
        rd(4'h0);
        chk({7'h00, got[2]}, 8'h00);
        wr(4'h2, 8'h01);
        wait_idle();
        rd(4'h2);
        chk(got, 8'h00);
        wr(4'h3, 8'hE0);
        wr(4'h5, 8'h77);
        rd(4'h3);
        chk(got, 8'hE0);
        for (int i = 0; i < 33; i++) begin
            wr(4'h5, i[7:0]);
            wr(4'h6, 8'hA0 ^ i[7:0]);
            rd(4'h3);
            chk(got, (i < 31) ? 8'hE1 + i[7:0] : 8'hFF);
        end
        rd(4'h4);
        chk(got, 8'h00);
        wr(4'h0, 8'h84);
        rd(4'h0);
        chk({7'h00, got[2]}, 8'h01);
        wait_idle();
        rd(4'h0);
        chk({7'h00, got[2]}, 8'h00);
        done("page write");
        wr(4'h0, 8'hB3);
        rd(4'h0);
        chk({7'h00, got[0]}, 8'h01);
        wait_idle();
        for (int j = 0; j < 32; j++) begin
            rdw(j[7:0], (j == 31) ? 16'h8020 : {8'hA0 ^ j[7:0], j[7:0]});
        end
        done("read back");
        op(8'h94);
        op(8'h84);
        rdw(8'h05, 16'hFFFF);
        wr(4'h3, 8'hE0);
        wr(4'h5, 8'h12);
        wr(4'h6, 8'h34);
        wr(4'h2, 8'h01);
        wait_idle();
        op(8'h84);
        rdw(8'h00, 16'hFFFF);
        wr(4'h0, 8'h00);
        rd(4'h0);
        chk({7'h00, got[7]}, 8'h00);
        done("buffer clear");
        // keys after the window ran out must not enable
        wr(4'h0, 8'h68);
        repeat (24) @(posedge core_clk);
        for (int k = 0; k < 4; k++) wr(4'h1, keys[k]);
        rd(4'h0);
        chk(got, 8'h60);
        rd(4'h2);
        chk(got, 8'h02);
        done("timeout");
        // reset in the middle of a word read
        wr(4'h0, 8'hB3);
        nrst <= 1'h0;
        repeat (2) @(posedge core_clk);
        nrst <= 1'h1;
        @(posedge core_clk);
        chk_busy();
        for (int i = 0; i < 13; i++) begin
            rd(i[3:0]);
            chk(got, 8'h00);
        end
        done("mid reset");
        report_and_stop();
    end
endmodule
`default_nettype wire
